// ===== verilog/sbcspi_pkg.sv
// sbcspi_pkg: constants and types of the serial command front end.
// assumes a 16-bit, lsb-first command frame from a host controller.
package sbcspi_pkg;

    // frame layout
    localparam int        FRAME_BITS     = 16;
    localparam logic [4:0] CNT_FULL      = 5'h10;
    localparam logic [4:0] CNT_MAX       = 5'h1f;
    localparam logic [4:0] CNT_RD_LOAD   = 5'h07;
    localparam int        RW_BIT         = 7;
    localparam int        DATA_LSB       = 8;

    // address map
    localparam logic [6:0] CTRL_TOP      = 7'h1e;
    localparam logic [6:0] STATUS_BASE   = 7'h40;
    localparam logic [6:0] STATUS_TOP    = 7'h7e;
    localparam logic [6:0] ADDR_MODE     = 7'h01;
    localparam logic [6:0] ADDR_SUPPLY   = 7'h02;
    localparam logic [6:0] ADDR_WD       = 7'h03;
    localparam logic [6:0] ADDR_TIMER    = 7'h0c;
    localparam logic [6:0] ADDR_DEVICE_STATUS_REG = 7'h43;
    localparam logic [6:0] ADDR_WK_LEVEL = 7'h48;
    localparam logic [6:0] ADDR_OSC_STAT = 7'h7d;
    localparam logic [6:0] ADDR_IDENT    = 7'h7e;

    // field positions inside the data byte
    localparam int        MODE_REQ_LSB   = 6;
    localparam int        LOAD_SHARE_POS = 3;
    localparam int        TMR_PER_LSB    = 0;
    localparam int        TMR_ON_LSB     = 4;

    // mode request codes in the mode control byte
    localparam logic [1:0] REQ_NORMAL    = 2'h0;
    localparam logic [1:0] REQ_SLEEP     = 2'h1;
    localparam logic [1:0] REQ_STOP      = 2'h2;
    localparam logic [1:0] REQ_RESET     = 2'h3;

    // reset values
    localparam logic       FAIL_RST      = 1'h0;
    localparam logic       ERR_RST       = 1'h0;

    typedef enum logic [2:0] {
        SBCSPI_INIT    = 3'b000,
        SBCSPI_NORMAL  = 3'b001,
        SBCSPI_STOP    = 3'b010,
        SBCSPI_SLEEP   = 3'b011,
        SBCSPI_RESTART = 3'b100
    } sbcspi_mode_t;

endpackage

// ===== verilog/sbcspi_frontend.sv
// sbcspi_frontend: serial command target, frame checks, command screening.
// assumes register contents and the mode machine live outside; serial pins
// and the reset-output pin are asynchronous and are synchronised here.
`timescale 1ns/100ps

// Contract
// - 16-bit frames, input sampled on falling clock
// - output shifted after rising clock, no chaining
// - interpret at select rise, release output
// - bad write ignored, sticky fail until cleared
// - stop to sleep fails, goes restart
// - init to stop/sleep fails, goes normal
// - watchdog byte odd parity fails, ignored
// - stop mode allows few commands only
// - stop with pending wake: interrupt, no fail
// - stop to normal ignores other bits, fails
// - sleep without wake sources fails, restart, executes
// - stop without sources accepted; timer-only sleep restarts
// - clearing active load share kept set, fails
// - sleep with measure and wake1/2 only fails
// - timer on-time not below period fails
// - all-zero or all-one frame fails
// - clock count not 0/16 discards, frame error
// - error bit out before first rising clock
// - reset pin overlap errors; output forced high
// - bits 6:0 address, 15:8 data byte
// - bit 7 write or clear; restart ignores all
// - response returns current byte of register
// - summary bit ors one status register; wake bit ors two
// - control and status address ranges, non-clearable
module sbcspi_frontend
(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    // serial link pins
    input  wire logic                      i_sclk,
    input  wire logic                      i_select_n,
    input  wire logic                      i_serial_in,
    output logic                           o_serial_out,
    output logic                           o_serial_out_oe_n,
    // device state
    input  wire sbcspi_pkg::sbcspi_mode_t  i_mode,
    input  wire logic                      i_reset_output_pin,
    input  wire logic                      i_bus_wake_cfg_zero,
    input  wire logic                      i_wake_stat_pending,
    input  wire logic                      i_load_share_on,
    input  wire logic                      i_wake_measure_bit,
    input  wire logic                      i_only_wake_one_two,
    input  wire logic                      i_timer_only_off,
    // status registers for the summary
    input  wire logic [7:0]                i_sup_stat_one,
    input  wire logic [7:0]                i_thermal_status_reg,
    input  wire logic [7:0]                i_device_status_reg,
    input  wire logic [7:0]                i_bus_status,
    input  wire logic [7:0]                i_wake_status_one,
    input  wire logic [7:0]                i_wake_status_two,
    input  wire logic [7:0]                i_sup_stat_two,
    input  wire logic [7:0]                i_switch_overload_status,
    input  wire logic [7:0]                i_switch_openload_status,
    // register read port
    output logic [6:0]                     o_rd_addr,
    input  wire logic [7:0]                i_rd_data,
    // decoded command
    output logic                           o_cmd_valid,
    output logic [6:0]                     o_cmd_addr,
    output logic                           o_cmd_write,
    output logic                           o_cmd_clear,
    output logic [7:0]                     o_cmd_data,
    output logic                           o_mode_req_valid,
    output sbcspi_pkg::sbcspi_mode_t       o_mode_req,
    output logic                           o_int_pulse,
    output logic                           o_fail_flag,
    output logic [7:0]                     o_status_summary,
    output logic                           o_frame_error
);
    import sbcspi_pkg::*;

    // two-flop synchronisers plus a third stage for edges
    logic [1:0] sclk_sync_reg;
    logic [1:0] sel_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] ro_sync_reg;
    logic       sclk_last_reg;
    logic       sel_last_reg;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sclk_sync_reg <= 2'h0;
            sel_sync_reg  <= 2'h3;
            sdi_sync_reg  <= 2'h0;
            ro_sync_reg   <= 2'h3;
            sclk_last_reg <= 1'h0;
            sel_last_reg  <= 1'h1;
        end
        else
        begin
            sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
            sel_sync_reg  <= {sel_sync_reg[0], i_select_n};
            sdi_sync_reg  <= {sdi_sync_reg[0], i_serial_in};
            ro_sync_reg   <= {ro_sync_reg[0], i_reset_output_pin};
            sclk_last_reg <= sclk_sync_reg[1];
            sel_last_reg  <= sel_sync_reg[1];
        end
    end

    wire sclk_s  = sclk_sync_reg[1];
    wire sel_s   = sel_sync_reg[1];
    wire ro_low  = ~ro_sync_reg[1];
    wire in_frm  = ~sel_s & ~sel_last_reg;
    wire cs_fall = ~sel_s & sel_last_reg;
    wire cs_rise = sel_s & ~sel_last_reg;
    wire sck_fall = in_frm & sclk_last_reg & ~sclk_s;
    wire sck_rise = in_frm & ~sclk_last_reg & sclk_s;

    function automatic logic any_set(input logic [7:0] b);
        any_set = |b;
    endfunction

    // summary of the status registers
    wire [7:0] summary_next = {
        any_set(i_switch_openload_status),
        any_set(i_switch_overload_status),
        any_set(i_sup_stat_two),
        any_set(i_wake_status_one | i_wake_status_two),
        any_set(i_bus_status),
        any_set(i_device_status_reg),
        any_set(i_thermal_status_reg),
        any_set(i_sup_stat_one)};

    // frame bookkeeping
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [7:0]  rd_byte_reg;
    logic [4:0]  cnt_reg;
    logic        clk_hi_reg;
    logic        ro_seen_reg;
    logic        err_pend_reg;
    logic        oe_n_reg;
    logic [7:0]  summary_reg;

    wire        clk_bad   = clk_hi_reg | sclk_s;
    wire        cnt_bad   = (cnt_reg != 5'h00) && (cnt_reg != CNT_FULL);
    wire        frame_bad = cnt_bad | clk_bad | ro_seen_reg | ro_low;
    wire        take      = cs_rise & ~frame_bad & (cnt_reg == CNT_FULL)
                            & (i_mode != SBCSPI_RESTART);
    wire [4:0]  cnt_inc   = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 5'h01;
    wire [15:0] tx_load   = {8'h00, summary_reg[6:0], err_pend_reg};

    assign o_rd_addr = rx_reg[15:9];

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            rx_reg       <= 16'h0000;
            tx_reg       <= 16'h0000;
            rd_byte_reg  <= 8'h00;
            cnt_reg      <= 5'h00;
            clk_hi_reg   <= 1'h0;
            ro_seen_reg  <= 1'h0;
            err_pend_reg <= ERR_RST;
            oe_n_reg     <= 1'h1;
            summary_reg  <= 8'h00;
        end
        else
        begin
            summary_reg <= summary_next;
            if (cs_fall)
            begin
                cnt_reg     <= 5'h00;
                clk_hi_reg  <= sclk_s;
                ro_seen_reg <= ro_low;
                tx_reg      <= tx_load;
                oe_n_reg    <= 1'h0;
            end
            else if (in_frm)
            begin
                ro_seen_reg <= ro_seen_reg | ro_low;
                if (sck_fall)
                begin
                    rx_reg  <= {sdi_sync_reg[1], rx_reg[15:1]};
                    cnt_reg <= cnt_inc;
                end
                if (sck_rise && cnt_reg == CNT_RD_LOAD)
                    rd_byte_reg <= i_rd_data;
                if (sck_rise && cnt_reg == CNT_RD_LOAD)
                    tx_reg <= {8'h00, i_rd_data};
                else if (sck_rise)
                    tx_reg <= {1'h0, tx_reg[15:1]};
            end
            if (cs_rise)
            begin
                oe_n_reg     <= 1'h1;
                err_pend_reg <= frame_bad;
            end
        end
    end

    assign o_serial_out      = ro_low | tx_reg[0];
    assign o_serial_out_oe_n = oe_n_reg;
    assign o_status_summary  = summary_reg;
    assign o_frame_error     = err_pend_reg;

    // command screening
    wire [6:0] addr   = rx_reg[6:0];
    wire       rw     = rx_reg[RW_BIT];
    wire [7:0] data   = rx_reg[15:DATA_LSB];
    wire [1:0] req    = data[MODE_REQ_LSB +: 2];
    wire       is_ctl = addr <= CTRL_TOP;
    wire       is_st  = (addr >= STATUS_BASE) && (addr <= STATUS_TOP);
    wire       no_clr = (addr == ADDR_WK_LEVEL) || (addr == ADDR_OSC_STAT)
                        || (addr == ADDR_IDENT);
    wire       stuck  = (rx_reg == 16'h0000) || (rx_reg == 16'hffff);
    wire       in_stp = i_mode == SBCSPI_STOP;
    wire       in_ini = i_mode == SBCSPI_INIT;
    wire       mw     = rw & (addr == ADDR_MODE);
    wire       r_slp  = mw & (req == REQ_SLEEP);
    wire       r_stp  = mw & (req == REQ_STOP);
    wire       r_nrm  = mw & (req == REQ_NORMAL);
    wire       r_rst  = mw & (req == REQ_RESET);
    wire       slp_ok = r_slp & ~in_stp & ~in_ini;

    wire f_stop_sleep = r_slp & in_stp;
    wire f_init       = (r_slp | r_stp) & in_ini;
    wire f_no_wake    = slp_ok & i_bus_wake_cfg_zero;
    wire f_measure    = slp_ok & i_wake_measure_bit & i_only_wake_one_two;
    wire timer_wake   = slp_ok & i_timer_only_off;
    wire f_other_bits = r_nrm & in_stp
                        & (data[MODE_REQ_LSB-1:0] != rd_byte_reg[MODE_REQ_LSB-1:0]);
    wire f_wd_parity  = rw & (addr == ADDR_WD) & (^data);
    wire f_stop_deny  = in_stp & rw & is_ctl & (addr != ADDR_WD)
                        & ~r_nrm & ~r_rst & ~r_slp;
    wire f_timer      = rw & (addr == ADDR_TIMER)
                        & (data[TMR_ON_LSB +: 3] >= {1'h0, data[TMR_PER_LSB +: 3]});
    wire f_load_share = rw & (addr == ADDR_SUPPLY) & i_load_share_on
                        & ~data[LOAD_SHARE_POS];

    wire fail = stuck | f_stop_sleep | f_init | f_no_wake | f_measure | f_other_bits
                | f_wd_parity | f_stop_deny | f_timer | f_load_share;
    wire blocked = stuck | f_wd_parity | f_stop_deny | f_timer | f_stop_sleep | f_init;
    wire wr_ok   = rw & is_ctl & ~blocked;
    wire clr_ok  = rw & is_st & ~no_clr & ~stuck;
    wire mode_ok = mw & ~stuck & ~f_stop_deny & ~f_wd_parity;

    wire [7:0] data_fix = f_other_bits
        ? {data[7:MODE_REQ_LSB], rd_byte_reg[MODE_REQ_LSB-1:0]}
        : (data | (f_load_share ? 8'h08 : 8'h00));

    sbcspi_mode_t mode_next;
    always_comb
    begin
        if (f_stop_sleep | f_no_wake | f_measure | timer_wake | r_rst)
            mode_next = SBCSPI_RESTART;
        else if (f_init | r_nrm)
            mode_next = SBCSPI_NORMAL;
        else if (r_slp)
            mode_next = SBCSPI_SLEEP;
        else
            mode_next = SBCSPI_STOP;
    end

    wire fail_clr  = take & clr_ok & (addr == ADDR_DEVICE_STATUS_REG);
    wire fail_set  = take & fail;
    wire fail_next = fail_set | (o_fail_flag & ~fail_clr);

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_cmd_valid      <= 1'h0;
            o_cmd_addr       <= 7'h00;
            o_cmd_write      <= 1'h0;
            o_cmd_clear      <= 1'h0;
            o_cmd_data       <= 8'h00;
            o_mode_req_valid <= 1'h0;
            o_mode_req       <= SBCSPI_INIT;
            o_int_pulse      <= 1'h0;
            o_fail_flag      <= FAIL_RST;
        end
        else
        begin
            o_cmd_valid      <= take;
            o_cmd_write      <= take & wr_ok;
            o_cmd_clear      <= take & clr_ok;
            o_mode_req_valid <= take & mode_ok;
            o_int_pulse      <= take & mode_ok & (mode_next == SBCSPI_STOP)
                                & i_wake_stat_pending;
            o_fail_flag      <= fail_next;
            if (take)
            begin
                o_cmd_addr <= addr;
                o_cmd_data <= data_fix;
                o_mode_req <= mode_next;
            end
        end
    end

    // checks
    property p_frame_err;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && cnt_bad |=> o_frame_error && !o_cmd_valid;
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("bad count not flagged");

    property p_release;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise |=> o_serial_out_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("output not released");

    property p_ro_high;
        @(posedge i_clk) disable iff (i_reset)
        ro_low |-> o_serial_out;
    endproperty
    a_ro_high: assert property (p_ro_high) else $error("output low during reset pin");

    property p_first_bit;
        @(posedge i_clk) disable iff (i_reset)
        cs_fall && !ro_low |=> o_serial_out == $past(err_pend_reg) && !o_serial_out_oe_n;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("error bit not first");

    property p_sticky;
        @(posedge i_clk) disable iff (i_reset)
        o_fail_flag && !fail_clr |=> o_fail_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("fail flag dropped");

    property p_restart;
        @(posedge i_clk) disable iff (i_reset)
        cs_rise && i_mode == SBCSPI_RESTART |=> !o_cmd_valid ##1 !o_cmd_valid;
    endproperty
    a_restart: assert property (p_restart) else $error("command in restart");

    property p_wd;
        @(posedge i_clk) disable iff (i_reset)
        o_cmd_write && o_cmd_addr == ADDR_WD |-> !(^o_cmd_data);
    endproperty
    a_wd: assert property (p_wd) else $error("odd watchdog byte written");

    property p_stuck;
        @(posedge i_clk) disable iff (i_reset)
        take && stuck |=> o_fail_flag && !o_cmd_write;
    endproperty
    a_stuck: assert property (p_stuck) else $error("stuck frame accepted");

    property p_load_share;
        @(posedge i_clk) disable iff (i_reset)
        take && f_load_share && wr_ok |=> o_cmd_write && o_cmd_data[LOAD_SHARE_POS] && o_fail_flag;
    endproperty
    a_load_share: assert property (p_load_share) else $error("load share cleared");

    property p_stop_sleep;
        @(posedge i_clk) disable iff (i_reset)
        take && f_stop_sleep |=> o_mode_req == SBCSPI_RESTART && o_fail_flag;
    endproperty
    a_stop_sleep: assert property (p_stop_sleep) else $error("stop to sleep passed");

    c_write: cover property (@(posedge i_clk) disable iff (i_reset) o_cmd_write);
    c_err: cover property (@(posedge i_clk) disable iff (i_reset) cs_rise && cnt_bad);
    c_fail_clr: cover property (@(posedge i_clk) disable iff (i_reset) fail_clr);
    c_int: cover property (@(posedge i_clk) disable iff (i_reset) o_int_pulse);

endmodule

// ===== bench/sbcspi_host_model.sv
// sbcspi_host_model: host controller that sends command frames.
// assumes the device clock paces it; serial clock is 8 device clocks.
`timescale 1ns/100ps
module sbcspi_host_model
(
    // device clock for pacing
    input  wire logic i_clk,
    // serial link
    output logic      o_sclk,
    output logic      o_select_n,
    output logic      o_serial_in,
    input  wire logic i_serial_out,
    input  wire logic i_serial_out_oe_n
);
    initial
    begin
        o_sclk = 1'b0;
        o_select_n = 1'b1;
        o_serial_in = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // lsb first, n clocks; a released line reads as unknown
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 'x;
        o_sclk = 1'b0;
        o_select_n = 1'b0;
        tick(6);
        r[0] = (i_serial_out_oe_n === 1'b0) ? i_serial_out : 1'bx;
        for (int i = 0; i < n; i++)
        begin
            r[i] = (i_serial_out_oe_n === 1'b0) ? i_serial_out : 1'bx;
            o_serial_in = w[i];
            o_sclk = 1'b1;
            tick(4);
            o_sclk = 1'b0;
            tick(4);
        end
        o_select_n = 1'b1;
        // idle data line shows no stale value
        o_serial_in = ~o_serial_in;
        tick(8);
    endtask
endmodule

// ===== bench/sbcspi_frontend_test.sv
// sbcspi_frontend_test: self-checking bench of the command front end.
// assumes the host model paces frames; status and read bytes come from here.
`timescale 1ns/100ps
module sbcspi_frontend_test;
    import sbcspi_pkg::*;
    typedef struct packed {
        logic [6:0]   addr;
        logic [4:0]   fl;
        sbcspi_mode_t mode;
        logic [7:0]   data;
    } sbcspi_exp_t;

    logic         i_clk = 1'b0;
    logic         i_reset = 1'b1;
    logic         i_sclk, i_select_n, i_serial_in, o_serial_out, o_serial_out_oe_n;
    sbcspi_mode_t i_mode = SBCSPI_INIT;
    sbcspi_mode_t o_mode_req;
    logic         i_reset_output_pin = 1'b1;
    logic         i_bus_wake_cfg_zero = 1'b0, i_wake_stat_pending = 1'b0, i_load_share_on = 1'b0;
    logic         i_wake_measure_bit = 1'b0, i_only_wake_one_two = 1'b0, i_timer_only_off = 1'b0;
    logic [71:0]  stv = '0;
    logic [7:0]   i_sup_stat_one, i_thermal_status_reg, i_device_status_reg, i_bus_status;
    logic [7:0]   i_wake_status_one, i_wake_status_two, i_sup_stat_two;
    logic [7:0]   i_switch_overload_status, i_switch_openload_status;
    logic [6:0]   o_rd_addr, o_cmd_addr;
    logic [7:0]   i_rd_data, o_cmd_data, o_status_summary;
    logic         o_cmd_valid, o_cmd_write, o_cmd_clear, o_mode_req_valid;
    logic         o_int_pulse, o_fail_flag, o_frame_error;
    logic [31:0]  lfsr = 32'h4965;
    logic         eerr = 1'b0;
    logic [15:0]  r;
    sbcspi_exp_t  expq[$];
    int           err_total = 0;
    int           checked = 0;
    int           cyc = 0;

    assign {i_switch_openload_status, i_switch_overload_status, i_sup_stat_two,
            i_wake_status_two, i_wake_status_one, i_bus_status, i_device_status_reg,
            i_thermal_status_reg, i_sup_stat_one} = stv;
    // register file stand-in: byte derived from address
    assign i_rd_data = {1'b0, o_rd_addr} ^ 8'h5a;

    sbcspi_frontend i_dut
    (
        .i_clk, .i_reset, .i_sclk, .i_select_n, .i_serial_in, .o_serial_out,
        .o_serial_out_oe_n, .i_mode, .i_reset_output_pin, .i_bus_wake_cfg_zero,
        .i_wake_stat_pending, .i_load_share_on, .i_wake_measure_bit, .i_only_wake_one_two,
        .i_timer_only_off, .i_sup_stat_one, .i_thermal_status_reg, .i_device_status_reg,
        .i_bus_status, .i_wake_status_one, .i_wake_status_two, .i_sup_stat_two,
        .i_switch_overload_status, .i_switch_openload_status, .o_rd_addr, .i_rd_data,
        .o_cmd_valid, .o_cmd_addr, .o_cmd_write, .o_cmd_clear, .o_cmd_data,
        .o_mode_req_valid, .o_mode_req, .o_int_pulse, .o_fail_flag, .o_status_summary,
        .o_frame_error
    );

    sbcspi_host_model u_host
    (
        .i_clk             (i_clk),
        .o_sclk            (i_sclk),
        .o_select_n        (i_select_n),
        .o_serial_in       (i_serial_in),
        .i_serial_out      (o_serial_out),
        .i_serial_out_oe_n (o_serial_out_oe_n)
    );

    always #12.5 i_clk = ~i_clk;

    function automatic logic [7:0] summ();
        logic [8:0] o;
        for (int k = 0; k < 9; k++)
            o[k] = |stv[k*8+:8];
        return {o[8:6], o[4] | o[5], o[3:0]};
    endfunction

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic complete_run();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask

    // fl = {write, clear, fail, interrupt, mode checked}
    task automatic chk_cmd(input sbcspi_exp_t e);
        checked++;
        if (o_cmd_addr !== e.addr || o_cmd_write !== e.fl[4] || o_cmd_clear !== e.fl[3]
            || o_fail_flag !== e.fl[2] || o_int_pulse !== e.fl[1]
            || (e.fl[4] && o_cmd_data !== e.data)
            || o_mode_req_valid !== e.fl[0] || (e.fl[0] && o_mode_req !== e.mode))
        begin
            err_total++;
            $display("[FAIL] %0t command at %h differs", $time, e.addr);
        end
    endtask

    always @(negedge i_clk)
    begin
        if (o_cmd_valid === 1'b1)
        begin
            if (expq.size() == 0)
                chk_val(16'h1, 16'h0, "unexpected command");
            else
                chk_cmd(expq.pop_front());
        end
    end

    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic cmd(input logic [15:0] w, input logic [4:0] fl, input sbcspi_mode_t md,
                       input logic [7:0] d);
        logic [7:0] s;
        s = summ();
        expq.push_back('{w[6:0], fl, md, d});
        u_host.frame(w, 16, r);
        chk_val(r, {{1'b0, w[6:0]} ^ 8'h5a, s[6:0], eerr}, "response");
        chk_val({15'h0, o_serial_out_oe_n}, 16'h1, "released");
        eerr = 1'b0;
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        chk_val({o_fail_flag, o_frame_error, o_serial_out_oe_n}, {FAIL_RST, ERR_RST, 1'b1}, "reset");
        i_mode = SBCSPI_NORMAL;
        u_host.frame(16'h0, 0, r);
        chk_val({15'h0, r[0]}, 16'h0, "zero clock");
        for (int n = 0; n < 4; n++)
        begin
            lfsr = lfsr_next(lfsr);
            for (int k = 0; k < 9; k++)
                stv[k*8+:8] = lfsr[k] ? lfsr[31:24] : 8'h00;
            cmd({lfsr[15:8], 8'h85}, 5'b10000, SBCSPI_INIT, lfsr[15:8]);
            cmd(16'h0005, 5'b00000, SBCSPI_INIT, 8'h00);
            chk_val({8'h0, o_status_summary}, {8'h0, summ()}, "summary");
        end
        cmd(16'h0383, 5'b10000, SBCSPI_INIT, 8'h03);
        cmd(16'h238c, 5'b10000, SBCSPI_INIT, 8'h23);
        cmd(16'h00c1, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h00c8, 5'b00000, SBCSPI_INIT, 8'h00);
        cmd(16'h55a0, 5'b00000, SBCSPI_INIT, 8'h55);
        u_host.frame(16'h1185, 8, r);
        chk_val({15'h0, o_frame_error}, 16'h1, "frame error");
        eerr = 1'b1;
        cmd(16'h0005, 5'b00000, SBCSPI_INIT, 8'h00);
        i_reset_output_pin = 1'b0;
        u_host.frame(16'h1185, 16, r);
        chk_val(r, 16'hffff, "reset pin");
        i_reset_output_pin = 1'b1;
        eerr = 1'b1;
        cmd(16'h0005, 5'b00000, SBCSPI_INIT, 8'h00);
        i_mode = SBCSPI_RESTART;
        u_host.frame(16'h1185, 16, r);
        i_mode = SBCSPI_NORMAL;
        i_wake_stat_pending = 1'b1;
        cmd(16'h8081, 5'b10011, SBCSPI_STOP, 8'h80);
        i_wake_stat_pending = 1'b0;
        i_timer_only_off = 1'b1;
        cmd(16'h4081, 5'b10001, SBCSPI_RESTART, 8'h40);
        i_timer_only_off = 1'b0;
        cmd(16'h0183, 5'b00100, SBCSPI_INIT, 8'h01);
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h338c, 5'b00100, SBCSPI_INIT, 8'h33);
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h0000, 5'b00100, SBCSPI_INIT, 8'h00);
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'hffff, 5'b00100, SBCSPI_INIT, 8'hff);
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        i_bus_wake_cfg_zero = 1'b1;
        cmd(16'h4081, 5'b10101, SBCSPI_RESTART, 8'h40);
        i_bus_wake_cfg_zero = 1'b0;
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        {i_wake_measure_bit, i_only_wake_one_two} = 2'b11;
        cmd(16'h4081, 5'b10101, SBCSPI_RESTART, 8'h40);
        {i_wake_measure_bit, i_only_wake_one_two} = 2'b00;
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        i_load_share_on = 1'b1;
        cmd(16'h0082, 5'b10100, SBCSPI_INIT, 8'h08);
        i_mode = SBCSPI_STOP;
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h0081, 5'b10101, SBCSPI_NORMAL, 8'h1b);
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h4081, 5'b00101, SBCSPI_RESTART, 8'h40);
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h1185, 5'b00100, SBCSPI_INIT, 8'h11);
        cmd(16'h0383, 5'b10100, SBCSPI_INIT, 8'h03);
        i_mode = SBCSPI_INIT;
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        cmd(16'h8081, 5'b00101, SBCSPI_NORMAL, 8'h80);
        cmd(16'h4081, 5'b00101, SBCSPI_NORMAL, 8'h40);
        i_mode = SBCSPI_NORMAL;
        cmd(16'h00c3, 5'b01000, SBCSPI_INIT, 8'h00);
        chk_val(expq.size(), 16'h0, "pending commands");
        complete_run();
    end
endmodule
